// ===== dv/dogag_ram_model.sv
// Data memory model: working register and result write port towards the decoder.
// Assumes the bench calls its tasks from one process, clear of the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dogag_ram_model
(
	input wire logic mclk,
	output logic wb_en,
	output logic [dogag_pkg::DADDR_W-1:0] wb_addr,
	output logic [dogag_pkg::FIELD_W-1:0] wb_data,
	output logic [dogag_pkg::FIELD_W-1:0] wreg_value
);
	import dogag_pkg::*;
	// Quiet write port at time zero
	initial
	begin
		wb_en = 1'b0;
		wb_addr = '0;
		wb_data = '0;
		wreg_value = '0;
	end
	// One result write, pointer bytes included; released lines show the inverse
	task automatic store(input logic [11:0] a, input logic [7:0] d);
		@(negedge mclk);
		wb_en = 1'b1;
		wb_addr = a;
		wb_data = d;
		@(negedge mclk);
		wb_en = 1'b0;
		wb_addr = ~a; // Stale address must never be trusted
		wb_data = ~d;
	endtask : store
	// Working register contents, used as the signed offset
	task automatic load_w(input logic [7:0] d);
		@(negedge mclk);
		wreg_value = d;
	endtask : load_w
endmodule : dogag_ram_model
`default_nettype wire

// ===== dv/test_data_operand_address_gen.sv
// Self-checking bench for the operand address generator.
// Assumes the decoder and the data memory model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); \
		end \
	end
module test_data_operand_address_gen;
	import dogag_pkg::*;
	logic mclk = 1'b0; // Core clock
	logic rst_b, instr_valid, extended_set_enable, wb_en;
	logic [15:0] instr_word, ext_word;
	logic [3:0] bank_select_value;
	logic [7:0] wreg_value, wb_data, literal_value, f, w;
	logic [11:0] wb_addr, src_addr, dst_addr;
	logic op_valid, src_is_file, literal_valid, prog_target_valid, indirect_access;
	logic [19:0] prog_target;
	dogag_dest_t dest_sel, exp_d;
	dogag_ptrs_t file_pointer;
	dogag_addr_t v, exp_s;
	dogag_addr_t exp_p [3]; // Bench copy of pointer values
	logic [31:0] r, r2;
	logic [3:0] c;
	logic [1:0] p;
	int seed = 70704;
	int fail_count = 0;
	int check_count = 0;
	int i, k;
	always #2.5 mclk = ~mclk; // 200 MHz
	dogag_ram_model ram_u (.mclk(mclk), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data),
		.wreg_value(wreg_value));
	dogag_decoder dut_u (.mclk(mclk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
		.ext_word(ext_word), .bank_select_value(bank_select_value), .extended_set_enable(extended_set_enable),
		.wreg_value(wreg_value), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data), .op_valid(op_valid),
		.src_addr(src_addr), .src_is_file(src_is_file), .dst_addr(dst_addr), .dest_sel(dest_sel),
		.literal_value(literal_value), .literal_valid(literal_valid), .prog_target(prog_target),
		.prog_target_valid(prog_target_valid), .indirect_access(indirect_access), .file_pointer(file_pointer));
	// Expected direct address from bank bit, field, bank and extended mode
	function automatic dogag_addr_t dir_addr(input logic a, input logic [7:0] fl, input logic [3:0] b,
		input logic x, input dogag_addr_t p2);
		if (a)
			return {b, fl};
		if (x && fl < ACCESS_SPLIT)
			return p2 + {4'h0, fl};
		return (fl < ACCESS_SPLIT) ? {ACCESS_LO_BANK, fl} : {ACCESS_HI_BANK, fl};
	endfunction : dir_addr
	// Address used by an indirect port kind
	function automatic dogag_addr_t ind_addr(input logic [2:0] kd, input dogag_addr_t pv, input logic [7:0] wv);
		case (kd)
			KIND_PREINC: return pv + PTR_STEP;
			KIND_PLUSW: return pv + {{4{wv[7]}}, wv}; // Signed offset
			default: return pv;
		endcase
	endfunction : ind_addr
	// Pointer value after the access; post forms step only afterwards
	function automatic dogag_addr_t nxt_ptr(input logic [2:0] kd, input dogag_addr_t pv);
		case (kd)
			KIND_POSTINC, KIND_PREINC: return pv + PTR_STEP;
			KIND_POSTDEC: return pv - PTR_STEP;
			default: return pv;
		endcase
	endfunction : nxt_ptr
	// One instruction with an idle cycle after; outputs are settled on return
	task automatic op(input logic [15:0] iw, input logic [15:0] ew);
		@(negedge mclk);
		instr_valid = 1'b1;
		instr_word = iw;
		ext_word = ew;
		@(negedge mclk);
		instr_valid = 1'b0;
	endtask : op
	// Load a pointer through its two data-mapped bytes
	task automatic set_ptr(input logic [1:0] ps, input dogag_addr_t pv);
		ram_u.store({IND_PAGE, ps, KIND_PTR_LO}, pv[7:0]);
		ram_u.store({IND_PAGE, ps, KIND_PTR_HI}, {4'h0, pv[11:8]});
		exp_p[ps] = pv;
		`CHK(file_pointer[ps], pv)
	endtask : set_ptr
	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	// Hang guard: running out counts as a mismatch
	initial
	begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		test_done;
	end
	// Main sequence
	initial
	begin
		rst_b = 1'b0;
		instr_valid = 1'b0;
		instr_word = '0;
		ext_word = '0;
		bank_select_value = '0;
		extended_set_enable = 1'b0;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		`CHK(file_pointer, '0)
		`CHK(dest_sel, DEST_NONE)
		// Banked byte op writing back to the file
		bank_select_value = 4'h5;
		op(16'h2310, 16'h0000);
		`CHK(src_addr, 12'h510)
		`CHK(src_is_file, 1'b1)
		`CHK(dst_addr, 12'h510)
		`CHK(dest_sel, DEST_FILE)
		// Implied targets
		op(16'h3110, 16'h0000);
		`CHK(dest_sel, DEST_FILE)
		op(16'h4110, 16'h0000);
		`CHK(dest_sel, DEST_WREG)
		op(16'h0000, 16'h0000);
		`CHK(op_valid, 1'b1)
		`CHK(dest_sel, DEST_NONE)
		// Literal and program target
		r = $random(seed);
		op({OPC_LITERAL, 4'h0, r[7:0]}, 16'h0000);
		`CHK(literal_value, r[7:0])
		`CHK(literal_valid, 1'b1)
		`CHK(src_is_file, 1'b0)
		op({OPC_BRANCH, 4'h0, r[7:0]}, {4'h0, r[19:8]});
		`CHK(prog_target, r[19:0])
		`CHK(prog_target_valid, 1'b1)
		// Full address move ignores the bank value
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			r2 = $random(seed);
			bank_select_value = r[15:12];
			op({OPC_FULL_MOVE, r[11:0] & 12'hEFF}, {4'h0, r2[11:0]});
			`CHK(src_addr, r[11:0] & 12'hEFF)
			`CHK(dst_addr, r2[11:0])
		end
		// Every indirect port kind on a freshly loaded pointer
		for (k = 0; k < 5; k++)
		begin
			r = $random(seed);
			p = 2'(k % 3);
			v = 12'h100 | {2'h0, r[9:0]};
			w = r[31:24];
			set_ptr(p, v);
			ram_u.load_w(w);
			op({OPC_BYTE_D, 4'h0, 3'h7, p, k[2:0]}, 16'h0000);
			`CHK(src_addr, ind_addr(k[2:0], v, w))
			`CHK(indirect_access, 1'b1)
			`CHK(file_pointer[p], nxt_ptr(k[2:0], v))
			exp_p[p] = nxt_ptr(k[2:0], v);
		end
		// Unknown class on a post-increment port: refused, pointer left alone
		op(16'h70E9, 16'h0000);
		`CHK(op_valid, 1'b0)
		`CHK(indirect_access, 1'b0)
		`CHK(file_pointer[1], exp_p[1])
		// Indexed offset only while the extended set is on
		set_ptr(2'h2, 12'h200);
		for (k = 0; k < 2; k++)
		begin
			extended_set_enable = k[0];
			op(16'h2030, 16'h0000);
			`CHK(src_addr, dir_addr(1'b0, 8'h30, 4'h0, k[0], 12'h200))
			`CHK(dest_sel, DEST_WREG)
		end
		// Random byte ops issued back to back
		for (i = 0; i <= 40; i++)
		begin
			@(negedge mclk);
			if (i > 0)
			begin
				`CHK(src_addr, exp_s)
				`CHK(dest_sel, exp_d)
				`CHK(indirect_access, 1'b0)
			end
			r = $random(seed);
			c = (r[9:8] == 2'h0) ? OPC_BYTE_TO_F : (r[9:8] == 2'h1) ? OPC_BYTE_TO_W : OPC_BYTE_D;
			f = r[7:0];
			if ((!r[10] || r[15:12] == 4'hF) && f >= 8'hE0)
				f[7] = 1'b0; // Keep clear of the indirect page
			bank_select_value = r[15:12];
			extended_set_enable = r[16];
			instr_valid = (i < 40);
			instr_word = {c, 2'b00, r[11], r[10], f};
			exp_s = dir_addr(r[10], f, r[15:12], r[16], exp_p[2]);
			exp_d = (c == OPC_BYTE_TO_W || (c == OPC_BYTE_D && !r[11])) ? DEST_WREG : DEST_FILE;
		end
		// Reset in mid-run clears the pointers
		rst_b = 1'b0;
		@(negedge mclk);
		`CHK(file_pointer, '0)
		`CHK(op_valid, 1'b0)
		`CHK(src_addr, 12'h000)
		rst_b = 1'b1;
		// First operation after the second release must issue normally
		bank_select_value = 4'h5;
		op(16'h2310, 16'h0000);
		`CHK(src_addr, 12'h510)
		`CHK(dest_sel, DEST_FILE)
		test_done;
	end
endmodule : test_data_operand_address_gen
`default_nettype wire

// ===== hw/dogag_decoder.sv
// Operand address generator: turns an instruction into data addresses,
// literal or program target, destination choice and pointer updates.
// Assumes instruction words are valid when instr_valid is high, one per cycle.
`timescale 1ns/1ps
`default_nettype none

module dogag_decoder
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic instr_valid,
	input wire logic [dogag_pkg::INSTR_W-1:0] instr_word,
	input wire logic [dogag_pkg::INSTR_W-1:0] ext_word,
	input wire logic [dogag_pkg::BANK_W-1:0] bank_select_value,
	input wire logic extended_set_enable,
	input wire logic [dogag_pkg::FIELD_W-1:0] wreg_value,
	input wire logic wb_en,
	input wire logic [dogag_pkg::DADDR_W-1:0] wb_addr,
	input wire logic [dogag_pkg::FIELD_W-1:0] wb_data,
	output logic op_valid,
	output logic [dogag_pkg::DADDR_W-1:0] src_addr,
	output logic src_is_file,
	output logic [dogag_pkg::DADDR_W-1:0] dst_addr,
	output dogag_pkg::dogag_dest_t dest_sel,
	output logic [dogag_pkg::FIELD_W-1:0] literal_value,
	output logic literal_valid,
	output logic [dogag_pkg::PTARGET_W-1:0] prog_target,
	output logic prog_target_valid,
	output logic indirect_access,
	output dogag_pkg::dogag_ptrs_t file_pointer
);
	import dogag_pkg::*;

	dogag_ptr_if pif(); // Link to pointer bank

	// Decoded fields
	logic [OPC_MSB-OPC_LSB:0] opc; // Instruction class
	logic [FIELD_W-1:0] field; // Low operand byte
	logic abit; // Bank bit
	logic dbit; // Destination bit
	dogag_addr_t raw_addr; // Address before indirection
	logic ind_hit; // Raw address is an indirect port
	logic [PSEL_W-1:0] ind_sel; // Pointer behind the port
	logic [KIND_W-1:0] ind_kind; // Port kind
	dogag_addr_t ind_ptr; // Selected pointer value
	dogag_addr_t w_ext; // Working register sign extended
	dogag_addr_t eff_addr; // Address after indirection
	dogag_addr_t idx_sum; // Indexed literal offset address

	// Registered outputs
	logic op_valid_q, op_valid_d;
	dogag_addr_t src_addr_q, src_addr_d;
	logic src_is_file_q, src_is_file_d;
	dogag_addr_t dst_addr_q, dst_addr_d;
	dogag_dest_t dest_sel_q, dest_sel_d;
	logic [FIELD_W-1:0] literal_q, literal_d;
	logic literal_valid_q, literal_valid_d;
	logic [PTARGET_W-1:0] target_q, target_d;
	logic target_valid_q, target_valid_d;
	logic indirect_q, indirect_d;

	dogag_ptr_bank u_ptr_bank
	(
		.mclk(mclk),
		.rst_b(rst_b),
		.pif(pif.bank)
	);

	assign file_pointer = pif.ptr;

	// Field extraction and direct address forming
	always_comb
	begin
		opc = instr_word[OPC_MSB:OPC_LSB];
		field = instr_word[FIELD_W-1:0];
		abit = instr_word[ABIT_POS];
		dbit = instr_word[DBIT_POS];
		idx_sum = pif.ptr[IDX_PTR] + DADDR_W'(field);
		if (opc == OPC_FULL_MOVE)
			raw_addr = instr_word[DADDR_W-1:0];
		else if (abit)
			raw_addr = {bank_select_value, field};
		else if (extended_set_enable && field < ACCESS_SPLIT)
			raw_addr = idx_sum;
		else if (field < ACCESS_SPLIT)
			raw_addr = {ACCESS_LO_BANK, field};
		else
			raw_addr = {ACCESS_HI_BANK, field};
	end

	// Indirect port detection; an indexed address is also checked, so it may chain
	always_comb
	begin
		ind_sel = raw_addr[PSEL_LSB+PSEL_W-1:PSEL_LSB];
		ind_kind = raw_addr[KIND_W-1:0];
		ind_hit = raw_addr[DADDR_W-1:DADDR_W-PAGE_W] == IND_PAGE && ind_sel != PSEL_NONE
			&& ind_kind <= KIND_PLUSW;
		ind_ptr = (ind_sel == PSEL_NONE) ? PTR_RESET : pif.ptr[ind_sel];
		w_ext = {{(DADDR_W-FIELD_W){wreg_value[FIELD_W-1]}}, wreg_value};
		eff_addr = raw_addr;
		pif.upd_en = '0;
		pif.upd_val = pif.ptr;
		// Only addressing classes may step a pointer; an unknown class must leave every pointer alone
		if (instr_valid && ind_hit && (opc == OPC_BYTE_D || opc == OPC_BYTE_TO_F || opc == OPC_BYTE_TO_W
			|| opc == OPC_FULL_MOVE))
		begin
			eff_addr = ind_ptr;
			unique case (ind_kind)
				KIND_POSTINC:
				begin
					// Access uses the old value; the bank holds the advanced one next cycle
					pif.upd_en[ind_sel] = 1'b1;
					pif.upd_val[ind_sel] = ind_ptr + PTR_STEP;
				end
				KIND_POSTDEC:
				begin
					pif.upd_en[ind_sel] = 1'b1;
					pif.upd_val[ind_sel] = ind_ptr - PTR_STEP;
				end
				KIND_PREINC:
				begin
					eff_addr = ind_ptr + PTR_STEP;
					pif.upd_en[ind_sel] = 1'b1;
					pif.upd_val[ind_sel] = ind_ptr + PTR_STEP;
				end
				KIND_PLUSW:
				begin
					// Offset access leaves the pointer itself alone
					eff_addr = ind_ptr + w_ext;
				end
				default:
				begin
					eff_addr = ind_ptr;
				end
			endcase
		end
	end

	// Ordinary result writes to pointer locations load the pointer bytes
	always_comb
	begin
		pif.wr_sel = wb_addr[PSEL_LSB+PSEL_W-1:PSEL_LSB];
		pif.wr_hi = wb_addr[KIND_W-1:0] == KIND_PTR_HI;
		pif.wr_data = wb_data;
		pif.wr_en = wb_en && wb_addr[DADDR_W-1:DADDR_W-PAGE_W] == IND_PAGE && pif.wr_sel != PSEL_NONE
			&& (wb_addr[KIND_W-1:0] == KIND_PTR_LO || pif.wr_hi);
	end

	// Next values of the issued operation
	always_comb
	begin
		op_valid_d = instr_valid;
		src_addr_d = src_addr_q;
		src_is_file_d = 1'b0;
		dst_addr_d = dst_addr_q;
		dest_sel_d = DEST_NONE;
		literal_d = literal_q;
		literal_valid_d = 1'b0;
		target_d = target_q;
		target_valid_d = 1'b0;
		indirect_d = 1'b0;
		if (instr_valid)
		begin
			unique case (opc)
				OPC_INHERENT:
				begin
					// Acts on the device as a whole; nothing to address
					dest_sel_d = DEST_NONE;
				end
				OPC_LITERAL:
				begin
					literal_d = field;
					literal_valid_d = 1'b1;
					dest_sel_d = DEST_WREG;
				end
				OPC_BYTE_D:
				begin
					src_addr_d = eff_addr;
					src_is_file_d = 1'b1;
					indirect_d = ind_hit;
					dst_addr_d = eff_addr;
					dest_sel_d = dbit ? DEST_FILE : DEST_WREG;
				end
				OPC_BYTE_TO_F:
				begin
					src_addr_d = eff_addr;
					src_is_file_d = 1'b1;
					indirect_d = ind_hit;
					dst_addr_d = eff_addr;
					dest_sel_d = DEST_FILE;
				end
				OPC_BYTE_TO_W:
				begin
					src_addr_d = eff_addr;
					src_is_file_d = 1'b1;
					indirect_d = ind_hit;
					dest_sel_d = DEST_WREG;
				end
				OPC_FULL_MOVE:
				begin
					// Both ends are full addresses; the bank value plays no part
					src_addr_d = eff_addr;
					src_is_file_d = 1'b1;
					indirect_d = ind_hit;
					dst_addr_d = ext_word[DADDR_W-1:0];
					dest_sel_d = DEST_FILE;
				end
				OPC_BRANCH:
				begin
					target_d = {ext_word[PTARGET_W-FIELD_W-1:0], field};
					target_valid_d = 1'b1;
				end
				default:
				begin
					// Unknown class is not issued: op_valid goes low, no effect
					op_valid_d = 1'b0;
				end
			endcase
		end
	end

	// Output registers
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op_valid_q <= 1'b0;
			src_addr_q <= PTR_RESET;
			src_is_file_q <= 1'b0;
			dst_addr_q <= PTR_RESET;
			dest_sel_q <= DEST_NONE;
			literal_q <= '0;
			literal_valid_q <= 1'b0;
			target_q <= '0;
			target_valid_q <= 1'b0;
			indirect_q <= 1'b0;
		end
		else
		begin
			op_valid_q <= op_valid_d;
			src_addr_q <= src_addr_d;
			src_is_file_q <= src_is_file_d;
			dst_addr_q <= dst_addr_d;
			dest_sel_q <= dest_sel_d;
			literal_q <= literal_d;
			literal_valid_q <= literal_valid_d;
			target_q <= target_d;
			target_valid_q <= target_valid_d;
			indirect_q <= indirect_d;
		end
	end

	assign op_valid = op_valid_q;
	assign src_addr = src_addr_q;
	assign src_is_file = src_is_file_q;
	assign dst_addr = dst_addr_q;
	assign dest_sel = dest_sel_q;
	assign literal_value = literal_q;
	assign literal_valid = literal_valid_q;
	assign prog_target = target_q;
	assign prog_target_valid = target_valid_q;
	assign indirect_access = indirect_q;

	// Checks on the issued operation
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	chk_bank_join: assert property (instr_valid && opc == OPC_BYTE_D && abit
		&& bank_select_value != ACCESS_HI_BANK |=> src_addr == {$past(bank_select_value), $past(field)})
		else $error("bank-relative address not formed from bank value");
	chk_access_low: assert property (instr_valid && opc == OPC_BYTE_D && !abit
		&& !extended_set_enable && field < ACCESS_SPLIT |=> src_addr == {ACCESS_LO_BANK, $past(field)})
		else $error("access bank address used bank value");
	chk_full_move: assert property (instr_valid && opc == OPC_FULL_MOVE
		|=> dst_addr == $past(ext_word[DADDR_W-1:0]) && dest_sel == DEST_FILE)
		else $error("full address move destination wrong");
	chk_dest_file: assert property (instr_valid && opc == OPC_BYTE_D && dbit
		|=> dest_sel == DEST_FILE && dst_addr == src_addr)
		else $error("result not written back to source register");
	chk_dest_wreg: assert property (instr_valid && opc == OPC_BYTE_D && !dbit
		|=> dest_sel == DEST_WREG)
		else $error("result not steered to working register");
	chk_implied_dest: assert property (instr_valid && (opc == OPC_BYTE_TO_W || opc == OPC_BYTE_TO_F)
		|=> dest_sel == ($past(opc) == OPC_BYTE_TO_W ? DEST_WREG : DEST_FILE))
		else $error("implied destination wrong");
	chk_literal: assert property (instr_valid && opc == OPC_LITERAL
		|=> literal_valid && literal_value == $past(field) && !src_is_file)
		else $error("literal not taken from opcode");
	chk_branch: assert property (instr_valid && opc == OPC_BRANCH
		|=> prog_target_valid && prog_target == {$past(ext_word[PTARGET_W-FIELD_W-1:0]), $past(field)})
		else $error("program target wrong");
	chk_post_inc: assert property (instr_valid && opc == OPC_BYTE_D && ind_hit && ind_kind == KIND_POSTINC
		&& !pif.wr_en |=> indirect_access && src_addr == $past(ind_ptr)
		&& file_pointer[$past(ind_sel)] == $past(ind_ptr) + PTR_STEP)
		else $error("post increment order wrong");
	chk_ptr_load: assert property (pif.wr_en && !pif.wr_hi
		|=> file_pointer[$past(pif.wr_sel)][FIELD_W-1:0] == $past(wb_data))
		else $error("pointer low byte not loaded");
	chk_index_gate: assert property (instr_valid && opc == OPC_BYTE_D && !abit && field < ACCESS_SPLIT
		&& extended_set_enable && !ind_hit |=> src_addr == $past(idx_sum))
		else $error("indexed offset address wrong");
endmodule : dogag_decoder
`default_nettype wire

// ===== hw/dogag_ptr_bank.sv
// File pointer registers, one per pointer, with auto update and byte writes.
// Assumes the decoder never asks two updates of one pointer in one cycle.
`timescale 1ns/1ps
`default_nettype none
module dogag_ptr_bank
(
	input wire logic mclk,
	input wire logic rst_b,
	dogag_ptr_if.bank pif
);
	import dogag_pkg::*;

	for (genvar i = 0; i < NUM_PTR; i++)
	begin : g_ptr
		dogag_addr_t ptr_q; // Pointer value
		dogag_addr_t ptr_d; // Next pointer value

		// Explicit writes come last so the byte software writes beats an auto step; the other byte takes the stepped value
		always_comb
		begin
			ptr_d = ptr_q;
			if (pif.upd_en[i])
			begin
				ptr_d = pif.upd_val[i];
			end
			if (pif.wr_en && pif.wr_sel == PSEL_W'(i))
			begin
				if (pif.wr_hi)
				begin
					ptr_d[DADDR_W-1:FIELD_W] = pif.wr_data[DADDR_W-FIELD_W-1:0];
				end
				else
				begin
					ptr_d[FIELD_W-1:0] = pif.wr_data;
				end
			end
		end

		// Pointer storage
		always_ff @(posedge mclk or negedge rst_b)
		begin
			if (!rst_b)
				ptr_q <= PTR_RESET;
			else
				ptr_q <= ptr_d;
		end

		assign pif.ptr[i] = ptr_q;
	end
endmodule : dogag_ptr_bank
`default_nettype wire

// ===== shared/dogag_pkg.sv
// Constants, field layouts and types for the data operand address generator.
// Assumes a 16-bit instruction word, a second word for long forms, and a 12-bit data space.
package dogag_pkg;
	localparam int unsigned DADDR_W = 12; // Data memory address width
	localparam int unsigned FIELD_W = 8; // Operand field / data byte width
	localparam int unsigned BANK_W = 4; // Bank select width
	localparam int unsigned PTARGET_W = 20; // Program target width
	localparam int unsigned INSTR_W = 16; // Instruction word width
	localparam int unsigned NUM_PTR = 3; // Number of file pointers
	localparam int unsigned PSEL_W = 2; // Pointer select width
	localparam int unsigned KIND_W = 3; // Indirect location kind width
	localparam int unsigned PAGE_W = 7; // Indirect page tag width
	// Instruction field positions
	localparam int unsigned OPC_MSB = 15;
	localparam int unsigned OPC_LSB = 12;
	localparam int unsigned DBIT_POS = 9;
	localparam int unsigned ABIT_POS = 8;
	localparam int unsigned PSEL_LSB = 3;
	// Instruction classes
	localparam logic [3:0] OPC_INHERENT = 4'h0;
	localparam logic [3:0] OPC_LITERAL = 4'h1;
	localparam logic [3:0] OPC_BYTE_D = 4'h2;
	localparam logic [3:0] OPC_BYTE_TO_F = 4'h3;
	localparam logic [3:0] OPC_BYTE_TO_W = 4'h4;
	localparam logic [3:0] OPC_FULL_MOVE = 4'hC;
	localparam logic [3:0] OPC_BRANCH = 4'hE;
	// Access bank split and the two halves it maps to
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	// Indirect operand port page: addr[11:5], pointer in addr[4:3], kind in addr[2:0]
	localparam logic [6:0] IND_PAGE = 7'h7F;
	localparam logic [1:0] PSEL_NONE = 2'h3;
	localparam logic [2:0] KIND_PLAIN = 3'h0;
	localparam logic [2:0] KIND_POSTINC = 3'h1;
	localparam logic [2:0] KIND_POSTDEC = 3'h2;
	localparam logic [2:0] KIND_PREINC = 3'h3;
	localparam logic [2:0] KIND_PLUSW = 3'h4;
	localparam logic [2:0] KIND_PTR_LO = 3'h5;
	localparam logic [2:0] KIND_PTR_HI = 3'h6;
	localparam logic [1:0] IDX_PTR = 2'h2; // Pointer used by indexed literal offset
	localparam logic [11:0] PTR_RESET = 12'h000;
	localparam logic [11:0] PTR_STEP = 12'h001;
	typedef logic [DADDR_W-1:0] dogag_addr_t;
	typedef logic [NUM_PTR-1:0][DADDR_W-1:0] dogag_ptrs_t;
	typedef enum logic [1:0] {DEST_NONE, DEST_WREG, DEST_FILE} dogag_dest_t;
endpackage : dogag_pkg

// ===== shared/dogag_ptr_if.sv
// Bundle between the decoder and its file pointer bank.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dogag_ptr_if;
	import dogag_pkg::*;
	logic [NUM_PTR-1:0] upd_en; // Auto update request per pointer
	dogag_ptrs_t upd_val; // Updated pointer values
	logic wr_en; // Explicit byte write to a pointer
	logic [PSEL_W-1:0] wr_sel; // Which pointer is written
	logic wr_hi; // High byte when set
	logic [FIELD_W-1:0] wr_data; // Byte written
	dogag_ptrs_t ptr; // Current pointer values
	modport bank (input upd_en, upd_val, wr_en, wr_sel, wr_hi, wr_data, output ptr);
	modport user (output upd_en, upd_val, wr_en, wr_sel, wr_hi, wr_data, input ptr);
endinterface : dogag_ptr_if
`default_nettype wire
